/* File: hdl/fesp_params.svh */
`ifndef FESP_PARAMS_SVH
`define FESP_PARAMS_SVH
// command bytes
`define FESP_CMD_SUSPEND 8'hB0
`define FESP_CMD_RESUME 8'h30
`define FESP_CMD_RESET 8'hF0
`define FESP_CMD_SECT_ERASE 8'h30
`define FESP_CMD_ERASE_SETUP 8'h80
// control block offsets (low address byte when control select is active)
`define FESP_OFS_SECTOR_LOCK 8'hC0
`define FESP_OFS_DEVICE_LOCK 8'hC2
`define FESP_SECURITY_BIT 7
// reset values
`define FESP_SECTOR_LOCK_RST 8'h00
`define FESP_SECURITY_RST 1'b0
// timing, clock period in ps
`define FESP_CLK_PS 4000
`define FESP_WINDOW_NS 100000
`define FESP_WINDOW_CYC ((`FESP_WINDOW_NS * 1000) / `FESP_CLK_PS)
`define FESP_SUSP_MIN_NS 100
`define FESP_SUSP_MIN_CYC ((`FESP_SUSP_MIN_NS * 1000 + `FESP_CLK_PS - 1) / `FESP_CLK_PS)
`define FESP_SUSP_MAX_NS 15000
`define FESP_SUSP_MAX_CYC ((`FESP_SUSP_MAX_NS * 1000) / `FESP_CLK_PS)
`define FESP_RESET_US 2000
`define FESP_RESET_CYC ((`FESP_RESET_US * 1000000) / `FESP_CLK_PS)
`define FESP_ERASE_US 100000
// scaled in two steps so the product stays inside 32-bit arithmetic
`define FESP_ERASE_CYC ((`FESP_ERASE_US * 1000) / (`FESP_CLK_PS / 1000))
`endif

/* File: hdl/fesp_pkg.sv */
package fesp_pkg;
  typedef enum logic [2:0] {
    FESP_IDLE, FESP_WINDOW, FESP_ERASING, FESP_SUSPENDING, FESP_SUSPENDED, FESP_RESETTING,
    FESP_BUSY_OTHER
  } fesp_state_t;
  typedef struct packed {
    logic wrEn;
    logic rdEn;
    logic ctrlSel;
    logic [7:0] addrLow;
    logic [7:0] data;
  } fesp_bus_t;
  typedef struct packed {
    logic toggleFlag;
    logic errorFlag;
    logic eraseWindowFlag;
  } fesp_status_t;
endpackage : fesp_pkg

/* File: hdl/fesp_timer.sv */
`timescale 1ns/10ps
// loadable down counter, done pulses one cycle once the count is down to one
module fesp_timer
  import fesp_pkg::*;
#(
  parameter int WIDTH = 32
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic stop,
  input wire logic [WIDTH-1:0] loadValue,
  output logic running,
  output logic done
);
  logic [WIDTH-1:0] count_reg;

  // stop has priority so an abort never leaves a stale done behind
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_reg <= '0;
      running <= 1'b0;
      done <= 1'b0;
    end else begin
      done <= 1'b0;
      if (stop) begin
        running <= 1'b0;
      end else if (load) begin
        count_reg <= loadValue;
        running <= 1'b1;
      end else if (running) begin
        if (count_reg <= {{(WIDTH-1){1'b0}}, 1'b1}) begin
          running <= 1'b0;
          done <= 1'b1;
        end else begin
          count_reg <= count_reg - {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule : fesp_timer

/* File: hdl/fesp_toggle.sv */
`timescale 1ns/10ps
// toggle flag: flips on each status read while active
module fesp_toggle
  import fesp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic active,
  input wire logic statusRead,
  output logic toggleFlag
);
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      toggleFlag <= 1'b0;
    end else if (active && statusRead) begin
      toggleFlag <= ~toggleFlag;
    end
  end
endmodule : fesp_toggle

/* File: hdl/fesp_ctrl.sv */
`timescale 1ns/10ps
// Function
// - 0xB0 write with sector select suspends
// - suspend only during erase, then read
// - suspend in window ends the window
// - toggle stops 0.1 to 15 us later
// - suspended sector reads invalid, others valid
// - suspended: only resume and reset accepted
// - reset while suspended invalidates erased sectors
// - 0x30 write with select resumes erase
// - protected sectors ignore program and erase
// - sector lock status, read only
// - device lock bit 7 security, read only
// - security blocks external programmers and sector lock loads
// - security cleared only by full erase
// - reset command returns to read array
// - reset ignored during program or bulk erase
// - reset aborts sector erase, milliseconds
// - 100 us append window, restarts, flag
// - erasing accepts only reset and suspend
`include "fesp_params.svh"
module flash_erase_suspend_protect_ctrl
  import fesp_pkg::*;
#(
  parameter int WINDOW_CYC = `FESP_WINDOW_CYC,
  parameter int RESET_CYC = `FESP_RESET_CYC,
  parameter int ERASE_CYC = `FESP_ERASE_CYC
) (
  input wire logic clk,
  input wire logic rstn,
  input wire fesp_bus_t hostBus,
  input wire logic [7:0] sectorSelect,
  input wire logic eraseSetupDone,
  input wire logic otherBusy,
  input wire logic bulkEraseDone,
  input wire logic [7:0] sectorLockIn,
  input wire logic sectorLockLoad,
  input wire logic securitySet,
  input wire logic extProgReq,
  output logic extProgGrant,
  output logic [7:0] readData,
  output logic readDataValid,
  output logic readInvalid,
  output fesp_status_t status,
  output logic [7:0] erasingSectors,
  output logic [7:0] invalidSectors,
  output logic eraseActive,
  output logic eraseDone
);
  fesp_state_t state_reg;
  logic [7:0] sectorLock_reg;
  logic security_reg;
  logic [7:0] eraseSet_reg;
  logic [7:0] invalid_reg;
  logic errorFlag_reg;
  logic anySel;
  logic flashWr;
  logic flashRd;
  logic [7:0] selUnprot;
  logic winLoad;
  logic winStop;
  logic winDone;
  logic winRun;
  logic ersLoad;
  logic ersStop;
  logic ersDone;
  logic ersRun;
  logic suspLoad;
  logic suspDone;
  logic rstLoad;
  logic rstDone;
  logic toggleActive;
  logic toggleOut;
  logic [7:0] readNext;

  assign anySel = |sectorSelect;
  assign flashWr = hostBus.wrEn && anySel && !hostBus.ctrlSel;
  assign flashRd = hostBus.rdEn && anySel && !hostBus.ctrlSel;
  assign selUnprot = sectorSelect & ~sectorLock_reg;

  // command decode per state
  always_comb begin
    winLoad = 1'b0;
    winStop = 1'b0;
    ersLoad = 1'b0;
    ersStop = 1'b0;
    suspLoad = 1'b0;
    rstLoad = 1'b0;
    case (state_reg)
      FESP_IDLE: begin
        // erase code into a protected sector is silently dropped
        if (eraseSetupDone && flashWr && hostBus.data == `FESP_CMD_SECT_ERASE
            && |selUnprot && !otherBusy) begin
          winLoad = 1'b1;
        end
      end
      FESP_WINDOW: begin
        if (flashWr && hostBus.data == `FESP_CMD_SUSPEND) begin
          winStop = 1'b1;
          suspLoad = 1'b1;
        end else if (flashWr && hostBus.data == `FESP_CMD_SECT_ERASE) begin
          winLoad = 1'b1;
        end else if (flashWr) begin
          winStop = 1'b1; // any other command aborts to read array
        end else if (winDone) begin
          ersLoad = 1'b1;
        end
      end
      FESP_ERASING: begin
        if (flashWr && hostBus.data == `FESP_CMD_SUSPEND) begin
          ersStop = 1'b1;
          suspLoad = 1'b1;
        end else if (flashWr && hostBus.data == `FESP_CMD_RESET) begin
          ersStop = 1'b1;
          rstLoad = 1'b1;
        end
      end
      FESP_SUSPENDED: begin
        if (flashWr && hostBus.data == `FESP_CMD_RESUME) begin
          ersLoad = 1'b1;
        end else if (flashWr && hostBus.data == `FESP_CMD_RESET) begin
          rstLoad = 1'b1;
        end
      end
      default: begin
      end
    endcase
  end

  fesp_timer #(.WIDTH(32)) u_window (
    .clk(clk),
    .rstn(rstn),
    .load(winLoad),
    .stop(winStop),
    .loadValue(32'(WINDOW_CYC)),
    .running(winRun),
    .done(winDone)
  );

  // erase timer restarts on resume; a real array would carry progress
  fesp_timer #(.WIDTH(32)) u_erase (
    .clk(clk),
    .rstn(rstn),
    .load(ersLoad),
    .stop(ersStop),
    .loadValue(32'(ERASE_CYC)),
    .running(ersRun),
    .done(ersDone)
  );

  // suspend latency sits at the lower bound
  fesp_timer #(.WIDTH(32)) u_suspend (
    .clk(clk),
    .rstn(rstn),
    .load(suspLoad),
    .stop(1'b0),
    .loadValue(32'(`FESP_SUSP_MIN_CYC)),
    .running(),
    .done(suspDone)
  );

  fesp_timer #(.WIDTH(32)) u_reset (
    .clk(clk),
    .rstn(rstn),
    .load(rstLoad),
    .stop(1'b0),
    .loadValue(32'(RESET_CYC)),
    .running(),
    .done(rstDone)
  );

  // main sequencer
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg <= FESP_IDLE;
    end else begin
      case (state_reg)
        FESP_IDLE: begin
          if (otherBusy) begin
            state_reg <= FESP_BUSY_OTHER;
          end else if (winLoad) begin
            state_reg <= FESP_WINDOW;
          end
        end
        FESP_WINDOW: begin
          if (suspLoad) begin
            state_reg <= FESP_SUSPENDING;
          end else if (winStop) begin
            state_reg <= FESP_IDLE;
          end else if (ersLoad) begin
            state_reg <= FESP_ERASING;
          end
        end
        FESP_ERASING: begin
          if (suspLoad) begin
            state_reg <= FESP_SUSPENDING;
          end else if (rstLoad) begin
            state_reg <= FESP_RESETTING;
          end else if (ersDone) begin
            state_reg <= FESP_IDLE;
          end
        end
        FESP_SUSPENDING: begin
          if (suspDone) begin
            state_reg <= FESP_SUSPENDED;
          end
        end
        FESP_SUSPENDED: begin
          if (ersLoad) begin
            state_reg <= FESP_ERASING;
          end else if (rstLoad) begin
            state_reg <= FESP_RESETTING;
          end
        end
        FESP_RESETTING: begin
          if (rstDone) begin
            state_reg <= FESP_IDLE;
          end
        end
        FESP_BUSY_OTHER: begin
          // reset command ignored while program or bulk erase runs
          if (!otherBusy) begin
            state_reg <= FESP_IDLE;
          end
        end
        default: begin
          state_reg <= FESP_IDLE;
        end
      endcase
    end
  end

  // sectors collected during the append window
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      eraseSet_reg <= 8'h00;
    end else if (winLoad) begin
      eraseSet_reg <= (state_reg == FESP_IDLE) ? selUnprot : (eraseSet_reg | selUnprot);
    end else if (state_reg == FESP_IDLE) begin
      eraseSet_reg <= 8'h00;
    end
  end

  // sectors whose contents are invalid after an aborted erase
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      invalid_reg <= 8'h00;
    end else if (rstLoad) begin
      invalid_reg <= invalid_reg | eraseSet_reg;
    end else if (ersDone || bulkEraseDone) begin
      invalid_reg <= bulkEraseDone ? 8'h00 : (invalid_reg & ~eraseSet_reg);
    end
  end

  // lock bits are loaded by the programming path only, never by the host
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sectorLock_reg <= `FESP_SECTOR_LOCK_RST;
      security_reg <= `FESP_SECURITY_RST;
    end else begin
      if (sectorLockLoad && !security_reg) begin
        sectorLock_reg <= sectorLockIn;
      end
      if (securitySet) begin
        security_reg <= 1'b1; // set wins over clear
      end else if (bulkEraseDone) begin
        security_reg <= 1'b0;
      end
    end
  end

  assign toggleActive = (state_reg == FESP_WINDOW) || (state_reg == FESP_ERASING)
      || (state_reg == FESP_SUSPENDING);
  fesp_toggle u_toggle (
    .clk(clk),
    .rstn(rstn),
    .active(toggleActive),
    .statusRead(flashRd && |(sectorSelect & eraseSet_reg)),
    .toggleFlag(toggleOut)
  );

  // register read mux
  always_comb begin
    readNext = 8'h00;
    if (hostBus.addrLow == `FESP_OFS_SECTOR_LOCK) begin
      readNext = sectorLock_reg;
    end else if (hostBus.addrLow == `FESP_OFS_DEVICE_LOCK) begin
      readNext[`FESP_SECURITY_BIT] = security_reg;
    end
  end

  // registered outputs
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      readData <= 8'h00;
      readDataValid <= 1'b0;
      readInvalid <= 1'b0;
      status <= '0;
      erasingSectors <= 8'h00;
      invalidSectors <= 8'h00;
      eraseActive <= 1'b0;
      eraseDone <= 1'b0;
      extProgGrant <= 1'b0;
      errorFlag_reg <= 1'b0;
    end else begin
      readData <= readNext;
      readDataValid <= hostBus.rdEn && hostBus.ctrlSel;
      readInvalid <= flashRd && (state_reg == FESP_SUSPENDED)
          && |(sectorSelect & eraseSet_reg);
      errorFlag_reg <= 1'b0;
      status.toggleFlag <= toggleOut;
      status.errorFlag <= errorFlag_reg;
      status.eraseWindowFlag <= (state_reg != FESP_WINDOW) && (state_reg != FESP_IDLE);
      erasingSectors <= eraseSet_reg;
      invalidSectors <= invalid_reg;
      eraseActive <= ersRun || winRun;
      eraseDone <= ersDone;
      extProgGrant <= extProgReq && !security_reg;
    end
  end
endmodule : flash_erase_suspend_protect_ctrl

/* File: bench/fesp_checker.sv */
`timescale 1ns/10ps
`include "fesp_params.svh"
module fesp_checker
  import fesp_pkg::*;
#(
  parameter int RESET_CYC = 30
) (
  input wire logic clk,
  input wire logic rstn,
  input wire fesp_bus_t hostBus,
  input wire logic [7:0] sectorSelect,
  input wire logic eraseSetupDone,
  input wire logic otherBusy,
  input wire logic bulkEraseDone,
  input wire logic [7:0] sectorLockIn,
  input wire logic sectorLockLoad,
  input wire logic securitySet,
  input wire logic extProgReq,
  input wire logic extProgGrant,
  input wire logic [7:0] readData,
  input wire logic readDataValid,
  input wire logic readInvalid,
  input wire fesp_status_t status,
  input wire logic [7:0] erasingSectors,
  input wire logic eraseActive,
  input wire logic eraseDone
);
  localparam int RST_MAX = RESET_CYC + 4;
  logic [7:0] lockH;
  logic secH;
  logic cmd;
  logic eraseCmd;
  // shadow copies of the lock and security state
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) lockH <= 8'h00;
    else if (sectorLockLoad && !secH) lockH <= sectorLockIn;
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) secH <= 1'b0;
    else if (securitySet) secH <= 1'b1;
    else if (bulkEraseDone) secH <= 1'b0;
  end
  assign cmd = hostBus.wrEn && !hostBus.ctrlSel && (sectorSelect != 8'h00);
  assign eraseCmd = cmd && eraseSetupDone && (hostBus.data == `FESP_CMD_SECT_ERASE);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_grant;
    rstn && $past(rstn) && (secH == $past(secH)) |-> extProgGrant == ($past(extProgReq) && !secH);
  endproperty
  a_grant: assert property (p_grant) else $error("grant vs security wrong");
  property p_rdv;
    hostBus.rdEn && hostBus.ctrlSel |=> readDataValid;
  endproperty
  a_rdv: assert property (p_rdv) else $error("no read valid");
  property p_lock;
    hostBus.rdEn && hostBus.ctrlSel && hostBus.addrLow == `FESP_OFS_SECTOR_LOCK
      |=> readData == $past(lockH);
  endproperty
  a_lock: assert property (p_lock) else $error("sector lock read wrong");
  property p_sec;
    hostBus.rdEn && hostBus.ctrlSel && hostBus.addrLow == `FESP_OFS_DEVICE_LOCK
      |=> readData == {$past(secH), 7'h00};
  endproperty
  a_sec: assert property (p_sec) else $error("device lock read wrong");
  property p_locked;
    eraseCmd && erasingSectors == 8'h00 && (sectorSelect & lockH) != 8'h00 && !$past(eraseCmd)
      |=> erasingSectors == 8'h00 [*2];
  endproperty
  a_locked: assert property (p_locked) else $error("locked sector erased");
  property p_idle_susp;
    cmd && hostBus.data == `FESP_CMD_SUSPEND && !eraseActive && erasingSectors == 8'h00
      && !$past(eraseCmd)
      |=> ##1 erasingSectors == 8'h00 && !eraseActive;
  endproperty
  a_idle_susp: assert property (p_idle_susp) else $error("idle suspend acted");
  property p_inval;
    hostBus.rdEn && !hostBus.ctrlSel && (sectorSelect & erasingSectors) == 8'h00 |=> !readInvalid;
  endproperty
  a_inval: assert property (p_inval) else $error("valid sector read invalid");
  property p_reset;
    cmd && hostBus.data == `FESP_CMD_RESET && eraseActive |-> ##[1:RST_MAX] !eraseActive;
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not abort");
  property p_window;
    eraseCmd && erasingSectors == 8'h00 && (sectorSelect & lockH) == 8'h00
      && !otherBusy && !$past(otherBusy)
      |-> ##2 !status.eraseWindowFlag && erasingSectors != 8'h00;
  endproperty
  a_window: assert property (p_window) else $error("window not open");
  c_susp: cover property (cmd && hostBus.data == `FESP_CMD_SUSPEND && eraseActive);
  c_inval: cover property (readInvalid);
  c_done: cover property (eraseDone);
endmodule : fesp_checker
bind flash_erase_suspend_protect_ctrl fesp_checker #(.RESET_CYC(RESET_CYC)) fesp_checker_inst (
  .clk, .rstn, .hostBus, .sectorSelect, .eraseSetupDone, .otherBusy, .bulkEraseDone, .sectorLockIn,
  .sectorLockLoad, .securitySet, .extProgReq, .extProgGrant, .readData, .readDataValid,
  .readInvalid, .status, .erasingSectors, .eraseActive, .eraseDone
);

/* File: bench/fesp_host_model.sv */
`timescale 1ns/10ps
module fesp_host_model
  import fesp_pkg::*;
(
  input wire logic clk,
  input wire logic [7:0] readData,
  input wire logic readInvalid,
  output fesp_bus_t hostBus,
  output logic [7:0] sectorSelect,
  output logic eraseSetupDone
);
  initial begin
    hostBus = '0;
    sectorSelect = 8'h00;
    eraseSetupDone = 1'b0;
  end
  // single write cycle; data flips afterwards so no stale byte lingers
  task automatic wr(input logic [7:0] d, input logic [7:0] s, input logic su);
    @(negedge clk);
    hostBus.wrEn = 1'b1;
    hostBus.data = d;
    sectorSelect = s;
    eraseSetupDone = su;
    @(negedge clk);
    hostBus.wrEn = 1'b0;
    hostBus.data = ~d;
    sectorSelect = 8'h00;
    eraseSetupDone = 1'b0;
  endtask : wr
  // read strobe; the registered answer stands only in the following cycle
  task automatic rd(input logic c, input logic [7:0] a, input logic [7:0] s,
                    output logic [7:0] q, output logic inv);
    @(negedge clk);
    hostBus.rdEn = 1'b1;
    hostBus.ctrlSel = c;
    hostBus.addrLow = a;
    sectorSelect = s;
    @(negedge clk);
    q = readData;
    inv = readInvalid;
    hostBus.rdEn = 1'b0;
    hostBus.ctrlSel = 1'b0;
    hostBus.addrLow = ~a;
    sectorSelect = 8'h00;
  endtask : rd
endmodule : fesp_host_model

/* File: bench/flash_erase_suspend_protect_ctrl_test.sv */
`timescale 1ns/10ps
`include "fesp_params.svh"
module flash_erase_suspend_protect_ctrl_test
  import fesp_pkg::*;
;
  typedef struct packed {logic [7:0] lockIn; logic [7:0] expRead;} fesp_row_t;
  fesp_row_t rows [4] = '{16'h0000, 16'hA5A5, 16'h8181, 16'hFFFF};
  logic clk, rstn, eraseSetupDone, otherBusy, bulkEraseDone, sectorLockLoad, securitySet;
  logic extProgReq, extProgGrant, readDataValid, readInvalid, eraseActive, eraseDone;
  logic [7:0] sectorSelect, sectorLockIn, readData, erasingSectors, invalidSectors, q;
  logic t1, t2, inv;
  fesp_bus_t hostBus;
  fesp_status_t status;
  int numErrors = 0;
  int checkCount = 0;
  int n;
  flash_erase_suspend_protect_ctrl #(.WINDOW_CYC(20), .RESET_CYC(30), .ERASE_CYC(50))
    flash_erase_suspend_protect_ctrl_inst (.clk, .rstn, .hostBus, .sectorSelect, .eraseSetupDone,
    .otherBusy, .bulkEraseDone, .sectorLockIn, .sectorLockLoad, .securitySet, .extProgReq,
    .extProgGrant, .readData, .readDataValid, .readInvalid, .status, .erasingSectors,
    .invalidSectors, .eraseActive, .eraseDone);
  fesp_host_model fesp_host_model_inst (.clk, .readData, .readInvalid, .hostBus, .sectorSelect,
    .eraseSetupDone);
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checkCount++;
    if (got !== exp) begin
      numErrors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic results;
    $display("errors=%0d checks=%0d", numErrors, checkCount);
    if (numErrors == 0 && checkCount > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : results
  task automatic wt(input int k);
    repeat (k) @(negedge clk);
  endtask : wt
  task automatic ld(input logic [7:0] v);
    @(negedge clk);
    sectorLockIn = v;
    sectorLockLoad = 1'b1;
    @(negedge clk);
    sectorLockLoad = 1'b0;
  endtask : ld
  // status flag lags the read by up to two cycles
  task automatic poll(input logic [7:0] s, output logic t);
    fesp_host_model_inst.rd(1'b0, 8'h00, s, q, inv);
    wt(2);
    t = status.toggleFlag;
  endtask : poll
  // watchdog well beyond the expected run
  initial begin
    #40000;
    numErrors++;
    results();
  end
  initial begin
    rstn = 1'b0;
    otherBusy = 1'b0; // program path not modelled here
    {bulkEraseDone, sectorLockIn, sectorLockLoad, securitySet, extProgReq} = '0;
    wt(5);
    rstn = 1'b1;
    fesp_host_model_inst.rd(1'b1, `FESP_OFS_SECTOR_LOCK, 8'h00, q, inv);
    chk(q, 8'h00);
    fesp_host_model_inst.rd(1'b1, `FESP_OFS_DEVICE_LOCK, 8'h00, q, inv);
    chk(q, 8'h00);
    foreach (rows[k]) begin
      ld(rows[k].lockIn);
      fesp_host_model_inst.rd(1'b1, `FESP_OFS_SECTOR_LOCK, 8'h00, q, inv);
      chk(q, rows[k].expRead);
    end
    // security set blocks the external port, full erase clears it
    securitySet = 1'b1;
    extProgReq = 1'b1;
    wt(1);
    securitySet = 1'b0;
    wt(3);
    chk({7'h00, extProgGrant}, 8'h00);
    fesp_host_model_inst.rd(1'b1, `FESP_OFS_DEVICE_LOCK, 8'h00, q, inv);
    chk(q, 8'h80);
    bulkEraseDone = 1'b1;
    wt(1);
    bulkEraseDone = 1'b0;
    wt(3);
    chk({7'h00, extProgGrant}, 8'h01);
    fesp_host_model_inst.rd(1'b1, `FESP_OFS_DEVICE_LOCK, 8'h00, q, inv);
    chk(q, 8'h00);
    extProgReq = 1'b0;
    fesp_host_model_inst.wr(`FESP_CMD_RESET, 8'h01, 1'b0);
    wt(40);
    // erase aimed at a locked sector, then stray suspend and resume
    ld(8'h02);
    fesp_host_model_inst.wr(`FESP_CMD_SECT_ERASE, 8'h02, 1'b1);
    fesp_host_model_inst.wr(`FESP_CMD_SUSPEND, 8'h01, 1'b0);
    fesp_host_model_inst.wr(`FESP_CMD_RESUME, 8'h01, 1'b0);
    wt(3);
    chk(erasingSectors, 8'h00);
    ld(8'h00);
    // first sector then an appended one, suspended inside the window
    fesp_host_model_inst.wr(`FESP_CMD_SECT_ERASE, 8'h01, 1'b1);
    fesp_host_model_inst.wr(`FESP_CMD_SECT_ERASE, 8'h04, 1'b0);
    wt(2);
    chk(erasingSectors, 8'h05);
    chk({7'h00, status.eraseWindowFlag}, 8'h00);
    fesp_host_model_inst.wr(`FESP_CMD_SUSPEND, 8'h01, 1'b0);
    poll(8'h01, t1);
    poll(8'h01, t2);
    chk({7'h00, t1 ^ t2}, 8'h01);
    wt(30);
    poll(8'h01, t1);
    poll(8'h01, t2);
    chk({7'h00, t1 ^ t2}, 8'h00);
    chk({7'h00, inv}, 8'h01);
    poll(8'h08, t1);
    chk({7'h00, inv}, 8'h00);
    fesp_host_model_inst.wr(`FESP_CMD_ERASE_SETUP, 8'h10, 1'b0);
    poll(8'h01, t1);
    chk({7'h00, inv}, 8'h01);
    chk(erasingSectors, 8'h05);
    fesp_host_model_inst.wr(`FESP_CMD_RESUME, 8'h01, 1'b0);
    poll(8'h01, t1);
    poll(8'h01, t2);
    chk({7'h00, t1 ^ t2}, 8'h01);
    for (n = 0; n < 200 && eraseDone !== 1'b1; n++) @(negedge clk);
    chk({7'h00, eraseDone}, 8'h01);
    // window runs out, then reset aborts the erase
    fesp_host_model_inst.wr(`FESP_CMD_SECT_ERASE, 8'h02, 1'b1);
    wt(25);
    chk({7'h00, status.eraseWindowFlag}, 8'h01);
    fesp_host_model_inst.wr(`FESP_CMD_RESET, 8'h02, 1'b0);
    wt(40);
    chk({7'h00, eraseActive}, 8'h00);
    // reset while suspended spoils the sector under erase
    fesp_host_model_inst.wr(`FESP_CMD_SECT_ERASE, 8'h08, 1'b1);
    wt(25);
    fesp_host_model_inst.wr(`FESP_CMD_SUSPEND, 8'h08, 1'b0);
    wt(30);
    fesp_host_model_inst.wr(`FESP_CMD_RESET, 8'h08, 1'b0);
    wt(40);
    chk(invalidSectors, 8'h0A);
    // program path busy: sector erase and reset both ignored
    otherBusy = 1'b1;
    wt(2);
    fesp_host_model_inst.wr(`FESP_CMD_SECT_ERASE, 8'h01, 1'b1);
    fesp_host_model_inst.wr(`FESP_CMD_RESET, 8'h01, 1'b0);
    wt(3);
    chk(erasingSectors, 8'h00);
    chk({7'h00, eraseActive}, 8'h00);
    chk({7'h00, status.errorFlag}, 8'h00);
    otherBusy = 1'b0;
    wt(3);
    chk({7'h00, status.eraseWindowFlag}, 8'h00);
    results();
  end
endmodule : flash_erase_suspend_protect_ctrl_test
